/* hw/within_consts.svh */
// Offsets, field positions and reset values of the within-window event block.
// Included by the package and the bench; definitions only.
`ifndef WITHIN_CONSTS_SVH
`define WITHIN_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_WITHIN_EVENT_STATUS 8'h2E
`define IDX_CONFIG 8'h40
`define IDX_UPPER_THRESHOLD 8'h41
`define IDX_LOWER_THRESHOLD 8'h42
`define IDX_DEBOUNCE_COUNT 8'h43
`define IDX_IRQ_STATUS 8'h44
`define IDX_IRQ_MASK 8'h45

// Status register field positions
`define POS_ACTIVE 7
`define POS_X_FLAG 5
`define POS_Y_FLAG 3
`define POS_Z_FLAG 1

// Config register field positions (axis enables follow x=2, y=1, z=0)
`define POS_LATCH_ENABLE 3
`define POS_LOGIC_SELECT 4
`define POS_RELATIVE 5
`define POS_WAKE_ON_WITHIN 6
`define POS_ROUTE_ONE 7
`define POS_ROUTE_TWO 8

// Reset values
`define RST_STATUS 8'h00
`define RST_CONFIG 9'h000
`define RST_UPPER 12'h000
`define RST_LOWER 12'h000
`define RST_DEBOUNCE 8'h00

`endif

/* hw/within_pkg.sv */
// Types shared by the within-window event block and its bench.
// Assumes the constants header sits in the include path.
`include "within_consts.svh"

package within_pkg;
    typedef logic [11:0] sample_t;
    typedef sample_t [2:0] triplet_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_rsp_t;

    typedef enum logic {
        ARMED = 1'b0,
        FIRED = 1'b1
    } latch_state_t;
endpackage

/* hw/within_threshold_event_status.sv */
// Within-window half of the data change detector: window test, debounce, status,
// interrupt routing and an AXI4-Lite register slave.
// Assumes samples, reference and the data-rate strobe come from logic on clk.
//
// Behaviour
// [RULE1] The combined active bit (bit 7) sets once the condition held for at least the debounce count of ticks.
// [RULE2] The combined active bit reads 0 when no enabled axis is inside the window, and resets to 0; latch mode keeps it set until the status read.
// [RULE3] An axis is inside only when strictly above the lower and strictly below the upper threshold.
// [RULE4] Enabled axis results combine as all-of or any-of, chosen by the logic select bit.
// [RULE5] Only enabled axes take part; with none enabled the function stays idle.
// [RULE6] With wake-on-within set, the wake/sleep timer is reset every tick while the active bit is set.
// [RULE7] Per-axis flags for x, y and z sit at bits 5, 3 and 1 and show strict inside-ness.
// [RULE8] The host heeds a per-axis flag only while that axis is enabled.
// [RULE9] In latch mode the per-axis flags are captured as the active bit rises and held until the status read.
// [RULE10] Without latching the per-axis flags refresh whenever active and the debounce count is reached.
// [RULE11] Without latching and with a zero debounce count the per-axis flags refresh on every tick.
// [RULE12] The active bit can be routed to either interrupt pin.
// [RULE13] In latch mode the active bit asserts only on a false-to-true change of the condition.
// [RULE14] Unused status bits read zero and writes to the status register are ignored.
module within_threshold_event_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire within_pkg::axi_req_t axi_req,
    output within_pkg::axi_rsp_t axi_rsp,
    input wire logic odr_tick,
    input wire within_pkg::triplet_t sample,
    input wire within_pkg::triplet_t reference,
    output logic interrupt_pin_one,
    output logic interrupt_pin_two,
    output logic wake_timer_reset,
    output logic irq
);
    import within_pkg::*;

    logic [8:0] config_reg;
    sample_t upper_threshold;
    sample_t lower_threshold;
    logic [7:0] within_debounce_count;
    logic irq_status;
    logic irq_mask;
    logic within_event_active;
    logic [2:0] within_flag;
    logic [7:0] held_count;
    latch_state_t latch_state;
    localparam logic [7:0] STATUS_RESET = `RST_STATUS;

    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    wire [2:0] axis_enable = config_reg[2:0];
    wire within_latch_enable = config_reg[`POS_LATCH_ENABLE];
    wire within_logic_select = config_reg[`POS_LOGIC_SELECT];
    wire relative_mode = config_reg[`POS_RELATIVE];
    wire wake_on_within_event = config_reg[`POS_WAKE_ON_WITHIN];

    // Window test per axis
    wire [2:0] axis_inside;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            wire sample_t delta = sample_t'(sample[g] - reference[g]);
            wire sample_t value = relative_mode ? delta : sample[g];
            // [RULE3] strict window compare
            assign axis_inside[g] = ($signed(value) > $signed(lower_threshold))
                && ($signed(value) < $signed(upper_threshold));
        end
    endgenerate

    // [RULE5] disabled axes drop out
    wire any_enabled = |axis_enable;
    wire [2:0] enabled_inside = axis_inside & axis_enable;
    // [RULE4] all-of or any-of
    wire all_inside = &(axis_inside | ~axis_enable);
    wire condition = any_enabled && (within_logic_select ? all_inside : |enabled_inside);

    // Count saturates so a long hold never wraps back below the debounce count
    wire [7:0] next_held = !condition ? 8'h00 : (held_count == 8'hFF) ? held_count : held_count + 8'h01;
    // [RULE1] debounce reached
    wire reached = condition && (next_held >= within_debounce_count);
    wire debounce_zero = (within_debounce_count == 8'h00);

    // Register bus decode
    wire aw_take = axi_req.awvalid && axi_rsp.awready;
    wire w_take = axi_req.wvalid && axi_rsp.wready;
    wire ar_take = axi_req.arvalid && axi_rsp.arready;
    wire write_go = !axi_rsp.awready && !axi_rsp.wready && !axi_rsp.bvalid;
    wire [7:0] w_index = aw_addr[9:2];
    wire [7:0] r_index = axi_req.araddr[9:2];
    wire w_aligned = (aw_addr[1:0] == 2'b00) && (aw_addr[31:10] == 22'h0);
    wire r_aligned = (axi_req.araddr[1:0] == 2'b00) && (axi_req.araddr[31:10] == 22'h0);
    wire [31:0] w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire wr_config = write_go && w_aligned && (w_index == `IDX_CONFIG);
    wire wr_upper = write_go && w_aligned && (w_index == `IDX_UPPER_THRESHOLD);
    wire wr_lower = write_go && w_aligned && (w_index == `IDX_LOWER_THRESHOLD);
    wire wr_debounce = write_go && w_aligned && (w_index == `IDX_DEBOUNCE_COUNT);
    wire wr_irq_status = write_go && w_aligned && (w_index == `IDX_IRQ_STATUS);
    wire wr_irq_mask = write_go && w_aligned && (w_index == `IDX_IRQ_MASK);
    // [RULE14] status writes accepted and dropped
    wire wr_status = write_go && w_aligned && (w_index == `IDX_WITHIN_EVENT_STATUS);
    wire wr_known = wr_config || wr_upper || wr_lower || wr_debounce || wr_irq_status || wr_irq_mask || wr_status;
    wire [31:0] merged = w_data & w_mask;
    wire status_read = ar_take && r_aligned && (r_index == `IDX_WITHIN_EVENT_STATUS);

    // [RULE7] [RULE14] flag positions, unused zero
    wire [7:0] status_word = {within_event_active, 1'b0, within_flag[2], 1'b0, within_flag[1], 1'b0,
        within_flag[0], 1'b0};
    logic [31:0] read_word;
    logic read_known;
    always_comb begin
        read_known = r_aligned;
        unique case (r_index)
            `IDX_WITHIN_EVENT_STATUS: read_word = {24'h000000, status_word};
            `IDX_CONFIG: read_word = {23'h0, config_reg};
            `IDX_UPPER_THRESHOLD: read_word = {20'h00000, upper_threshold};
            `IDX_LOWER_THRESHOLD: read_word = {20'h00000, lower_threshold};
            `IDX_DEBOUNCE_COUNT: read_word = {24'h000000, within_debounce_count};
            `IDX_IRQ_STATUS: read_word = {31'h0, irq_status};
            `IDX_IRQ_MASK: read_word = {31'h0, irq_mask};
            default: begin
                read_word = 32'h00000000;
                read_known = 1'b0;
            end
        endcase
    end

    // Event timing
    wire fire_latched = odr_tick && reached && (latch_state == ARMED);
    wire next_active_live = reached;
    wire event_rise = odr_tick && !within_event_active
        && (within_latch_enable ? fire_latched : next_active_live);

    // Bus write channels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            axi_rsp.awready <= 1'b1;
            axi_rsp.wready <= 1'b1;
            axi_rsp.bvalid <= 1'b0;
            axi_rsp.bresp <= 2'b00;
            aw_addr <= 32'h00000000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (clk_en) begin
            if (aw_take) begin
                aw_addr <= axi_req.awaddr;
                axi_rsp.awready <= 1'b0;
            end
            if (w_take) begin
                w_data <= axi_req.wdata;
                w_strb <= axi_req.wstrb;
                axi_rsp.wready <= 1'b0;
            end
            if (write_go) begin
                axi_rsp.bvalid <= 1'b1;
                axi_rsp.bresp <= wr_known ? 2'b00 : 2'b10;
            end
            if (axi_rsp.bvalid && axi_req.bready) begin
                axi_rsp.bvalid <= 1'b0;
                axi_rsp.awready <= 1'b1;
                axi_rsp.wready <= 1'b1;
            end
        end
    end

    // Bus read channel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            axi_rsp.arready <= 1'b1;
            axi_rsp.rvalid <= 1'b0;
            axi_rsp.rdata <= 32'h00000000;
            axi_rsp.rresp <= 2'b00;
        end else if (clk_en) begin
            if (ar_take) begin
                axi_rsp.arready <= 1'b0;
                axi_rsp.rvalid <= 1'b1;
                axi_rsp.rdata <= read_word;
                axi_rsp.rresp <= read_known ? 2'b00 : 2'b10;
            end else if (axi_rsp.rvalid && axi_req.rready) begin
                axi_rsp.rvalid <= 1'b0;
                axi_rsp.arready <= 1'b1;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            config_reg <= `RST_CONFIG;
            upper_threshold <= `RST_UPPER;
            lower_threshold <= `RST_LOWER;
            within_debounce_count <= `RST_DEBOUNCE;
            irq_mask <= 1'b0;
        end else if (clk_en) begin
            if (wr_config) config_reg <= (config_reg & ~w_mask[8:0]) | merged[8:0];
            if (wr_upper) upper_threshold <= (upper_threshold & ~w_mask[11:0]) | merged[11:0];
            if (wr_lower) lower_threshold <= (lower_threshold & ~w_mask[11:0]) | merged[11:0];
            if (wr_debounce) within_debounce_count <= (within_debounce_count & ~w_mask[7:0]) | merged[7:0];
            if (wr_irq_mask) irq_mask <= (irq_mask & ~w_mask[0]) | merged[0];
        end
    end

    // Debounce counter advances once per data-rate tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held_count <= 8'h00;
        end else if (clk_en && odr_tick) begin
            held_count <= next_held;
        end
    end

    // [RULE13] re-arm once the condition drops or latch mode is cleared
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_state <= ARMED;
        end else if (clk_en && odr_tick) begin
            unique case (latch_state)
                ARMED: if (fire_latched && within_latch_enable) latch_state <= FIRED;
                FIRED: if (!condition || !within_latch_enable) latch_state <= ARMED;
            endcase
        end
    end

    // Active bit and per-axis flags; a capture beats a clearing read in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            within_event_active <= STATUS_RESET[`POS_ACTIVE];
            within_flag <= 3'b000;
        end else if (clk_en) begin
            if (within_latch_enable) begin
                // [RULE9] capture on rise, hold until read
                if (fire_latched) begin
                    within_event_active <= 1'b1;
                    within_flag <= enabled_inside;
                end else if (status_read) begin
                    within_event_active <= 1'b0;
                    within_flag <= 3'b000;
                end
            end else if (odr_tick) begin
                // [RULE1] [RULE2] live active bit
                within_event_active <= next_active_live;
                // [RULE10] [RULE11] live refresh
                if (reached || debounce_zero) within_flag <= enabled_inside;
            end
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= 1'b0;
        end else if (clk_en) begin
            if (event_rise) irq_status <= 1'b1;
            else if (wr_irq_status && w_strb[0] && w_data[0]) irq_status <= 1'b0;
        end
    end

    // Pins and wake timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interrupt_pin_one <= 1'b0;
            interrupt_pin_two <= 1'b0;
            wake_timer_reset <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            // [RULE12] pin routing
            interrupt_pin_one <= within_event_active && config_reg[`POS_ROUTE_ONE];
            interrupt_pin_two <= within_event_active && config_reg[`POS_ROUTE_TWO];
            // [RULE6] hold off sleep each tick
            wake_timer_reset <= odr_tick && within_event_active && wake_on_within_event;
            irq <= irq_status && irq_mask;
        end
    end

    // Checks
    sequence tick_held_s;
        clk_en && odr_tick && reached && !within_latch_enable;
    endsequence
    sequence latch_fire_s;
        clk_en && fire_latched && within_latch_enable;
    endsequence

    active_sets_a: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        tick_held_s |=> within_event_active)
        else $error("active bit missed debounce");
    active_clear_a: assert property (@(posedge clk) disable iff (rst) // [RULE2]
        clk_en && odr_tick && !within_latch_enable && !condition |=> !within_event_active)
        else $error("active bit set outside window");
    idle_none_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
        !any_enabled |-> !condition && !reached)
        else $error("detector active with no axis enabled");
    wake_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE6]
        clk_en && odr_tick && within_event_active && wake_on_within_event |=> wake_timer_reset)
        else $error("wake timer not reset");
    unused_zero_a: assert property (@(posedge clk) disable iff (rst) // [RULE14]
        axi_rsp.rvalid && $past(status_read) |-> axi_rsp.rdata[6] == 1'b0 && axi_rsp.rdata[0] == 1'b0)
        else $error("unused status bit nonzero");
    latch_capture_a: assert property (@(posedge clk) disable iff (rst) // [RULE9]
        latch_fire_s |=> within_flag == $past(enabled_inside) && within_event_active)
        else $error("flags not captured on rise");
    read_clears_a: assert property (@(posedge clk) disable iff (rst) // [RULE9]
        clk_en && within_latch_enable && status_read && !fire_latched |=> within_flag == 3'b000)
        else $error("status read did not clear flags");
    live_zero_a: assert property (@(posedge clk) disable iff (rst) // [RULE11]
        clk_en && odr_tick && !within_latch_enable && debounce_zero |=> within_flag == $past(enabled_inside))
        else $error("flags not refreshed with zero count");
    single_fire_a: assert property (@(posedge clk) disable iff (rst) // [RULE13]
        latch_fire_s |=> latch_state == FIRED)
        else $error("latch did not wait for condition to drop");
    pin_route_a: assert property (@(posedge clk) disable iff (rst) // [RULE12]
        clk_en && within_event_active && config_reg[`POS_ROUTE_ONE] |=> interrupt_pin_one)
        else $error("pin one not driven");
endmodule

/* dv/host_model.sv */
// Host side of the block: an AXI4-Lite master doing one access at a time.
// Assumes the block shares clk; only the bench watchdog ends a wait.
module host_model (
    input wire logic clk,
    output within_pkg::axi_req_t axi_req,
    input wire within_pkg::axi_rsp_t axi_rsp
);
    import within_pkg::*;

    initial axi_req = '0;

    task automatic write_reg(input logic [7:0] idx, input logic [31:0] data, output logic [1:0] resp);
        logic aw_left;
        logic w_left;
        @(posedge clk);
        axi_req.awaddr <= {22'h0, idx, 2'b00};
        axi_req.awvalid <= 1'b1;
        axi_req.wdata <= data;
        axi_req.wstrb <= 4'hF;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        aw_left = 1'b1;
        w_left = 1'b1;
        while (aw_left || w_left) begin
            @(posedge clk);
            // Released lines show the inverse, never a stale copy
            if (aw_left && axi_rsp.awready === 1'b1) begin
                aw_left = 1'b0;
                axi_req.awvalid <= 1'b0;
                axi_req.awaddr <= ~axi_req.awaddr;
            end
            if (w_left && axi_rsp.wready === 1'b1) begin
                w_left = 1'b0;
                axi_req.wvalid <= 1'b0;
                axi_req.wdata <= ~data;
            end
        end
        while (axi_rsp.bvalid !== 1'b1) @(posedge clk);
        resp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask

    task automatic read_reg(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
        @(posedge clk);
        axi_req.araddr <= {22'h0, idx, 2'b00};
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do @(posedge clk); while (axi_rsp.arready !== 1'b1);
        axi_req.arvalid <= 1'b0;
        axi_req.araddr <= ~axi_req.araddr;
        while (axi_rsp.rvalid !== 1'b1) @(posedge clk);
        data = axi_rsp.rdata;
        resp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask

    function automatic logic [7:0] heeded(input logic [7:0] status, input logic [2:0] en);
        return status & {2'b10, en[2], 1'b0, en[1], 1'b0, en[0], 1'b0};
    endfunction
endmodule

/* dv/within_threshold_event_status_tb.sv */
// Bench for the within-window block: integer model compared at every tick and read.
// Assumes the constants header in the include path; clk_en drops once to show the freeze.
`include "within_consts.svh"
module within_threshold_event_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import within_pkg::*;

    logic clk;
    logic rst;
    logic clk_en;
    logic odr_tick;
    triplet_t sample;
    triplet_t reference;
    axi_req_t axi_req;
    axi_rsp_t axi_rsp;
    logic interrupt_pin_one;
    logic interrupt_pin_two;
    logic wake_timer_reset;
    logic irq;
    int errors;
    int num_checks;
    int wake_cnt;
    logic [31:0] lfsr = 32'h6FFC;
    int lo = -8;
    int up = 8;
    int deb;
    int cnt;
    logic [8:0] cfg = 9'h000;
    logic [2:0] flags = 3'h0;
    bit act;
    bit armed = 1'b1;
    bit irqs;
    bit mask;

    within_threshold_event_status u_dut (
        .clk(clk), .rst(rst), .clk_en(clk_en), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .odr_tick(odr_tick), .sample(sample), .reference(reference),
        .interrupt_pin_one(interrupt_pin_one), .interrupt_pin_two(interrupt_pin_two),
        .wake_timer_reset(wake_timer_reset), .irq(irq)
    );
    host_model u_host (.clk(clk), .axi_req(axi_req), .axi_rsp(axi_rsp));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) if (wake_timer_reset === 1'b1) wake_cnt <= wake_cnt + 1;

    function automatic int rnd(input int span);
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return int'(lfsr[15:0]) % span;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic tick(input int x, input int y, input int z, input int r);
        int vals[3] = '{z, y, x};
        int v;
        logic [2:0] ins;
        bit cond;
        bit reached;
        bit prev;
        int wake_base;
        @(posedge clk);
        sample <= {12'(x), 12'(y), 12'(z)};
        reference <= {3{12'(r)}};
        odr_tick <= 1'b1;
        wake_base = wake_cnt;
        @(posedge clk);
        odr_tick <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            v = vals[i] - (cfg[`POS_RELATIVE] ? r : 0);
            ins[i] = cfg[i] && v > lo && v < up;
        end
        cond = cfg[`POS_LOGIC_SELECT] ? (cfg[2:0] != 3'h0 && ins == cfg[2:0]) : (ins != 3'h0);
        cnt = cond ? ((cnt < 255) ? cnt + 1 : 255) : 0;
        reached = cond && cnt >= deb;
        prev = act;
        if (!cfg[`POS_LATCH_ENABLE]) begin
            act = reached;
            if (reached || deb == 0) flags = ins;
        end else if (!cond) begin
            armed = 1'b1;
        end else if (armed && reached) begin
            act = 1'b1;
            flags = ins;
            armed = 1'b0;
        end
        if (act && !prev) irqs = 1'b1;
        repeat (4) @(posedge clk);
        // Wake pulse follows the active bit as it stood when the tick arrived
        check("wake pulses", (prev && cfg[`POS_WAKE_ON_WITHIN]) ? 32'h1 : 32'h0, 32'(wake_cnt - wake_base));
        check("pins", {30'h0, act & cfg[`POS_ROUTE_TWO], act & cfg[`POS_ROUTE_ONE]},
            {30'h0, interrupt_pin_two, interrupt_pin_one});
        check("irq", {31'h0, irqs & mask}, {31'h0, irq});
    endtask

    task automatic read_status();
        logic [31:0] d;
        logic [1:0] resp;
        logic [31:0] exp;
        exp = {24'h0, act, 1'b0, flags[2], 1'b0, flags[1], 1'b0, flags[0], 1'b0};
        u_host.read_reg(`IDX_WITHIN_EVENT_STATUS, d, resp);
        check("status", exp, d);
        check("heeded", {24'h0, u_host.heeded(exp[7:0], cfg[2:0])}, {24'h0, u_host.heeded(d[7:0], cfg[2:0])});
        if (cfg[`POS_LATCH_ENABLE]) begin
            act = 1'b0;
            flags = 3'h0;
        end
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        give_verdict();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] resp;
        rst = 1'b1;
        clk_en = 1'b1;
        odr_tick = 1'b0;
        sample = '0;
        reference = '0;
        errors = 0;
        num_checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            u_host.read_reg(k == 0 ? `IDX_WITHIN_EVENT_STATUS : 8'(8'h3F + k), d, resp);
            check("reset value", 32'h0, d);
        end
        u_host.write_reg(`IDX_WITHIN_EVENT_STATUS, 32'hFFFFFFFF, resp);
        check("status write resp", 32'h0, 32'(resp));
        read_status();
        u_host.read_reg(8'h30, d, resp);
        check("unmapped resp", 32'h2, 32'(resp));
        check("unmapped data", 32'h0, d);
        u_host.write_reg(`IDX_LOWER_THRESHOLD, 32'h00000FF8, resp);
        u_host.write_reg(`IDX_UPPER_THRESHOLD, 32'h00000008, resp);
        for (int n = 0; n < 400; n++) begin
            if (n % 20 == 0) begin
                // Quiet tick first so a mode change never lands mid-event
                tick(2047, 2047, 2047, 0);
                read_status();
                cfg = 9'(rnd(512));
                deb = rnd(4);
                mask = 1'(rnd(2));
                u_host.write_reg(`IDX_CONFIG, {23'h0, cfg}, resp);
                u_host.write_reg(`IDX_DEBOUNCE_COUNT, 32'(deb), resp);
                u_host.write_reg(`IDX_IRQ_MASK, {31'h0, mask}, resp);
            end
            tick(rnd(25) - 12, rnd(25) - 12, rnd(25) - 12, rnd(9) - 4);
            read_status();
            if (n % 7 == 0) begin
                u_host.read_reg(`IDX_IRQ_STATUS, d, resp);
                check("irq status", {31'h0, irqs}, d);
                u_host.write_reg(`IDX_IRQ_STATUS, 32'h1, resp);
                irqs = 1'b0;
            end
        end
        // Frozen clock enable: a tick inside the window must leave status untouched
        cfg = 9'h007;
        deb = 0;
        u_host.write_reg(`IDX_CONFIG, {23'h0, cfg}, resp);
        u_host.write_reg(`IDX_DEBOUNCE_COUNT, 32'h0, resp);
        tick(2047, 2047, 2047, 0);
        @(posedge clk);
        clk_en <= 1'b0;
        sample <= '0;
        odr_tick <= 1'b1;
        @(posedge clk);
        odr_tick <= 1'b0;
        @(posedge clk);
        clk_en <= 1'b1;
        read_status();
        give_verdict();
    end
endmodule
